//--- design/mfr_top.sv
// module: fault-response configuration and handling for a motor driver
// Behaviour
// - lock codes 0h-3h latch a lock fault, pull the fault pin low and set stage off, recirc, high-side or low-side.
// - lock codes 4h-7h clear a lock fault after the retry wait, same stages, and latch once retries are used up.
// - lock code 8h only reports a lock event and leaves the output stage running.
// - lock codes 9h-Fh disable lock detection; the mode field is four bits.
// - the lock condition is deglitched for code times one microsecond, code 0 meaning no filtering.
// - a three-bit code selects the low supply limit, 0 none, else 4.5 to 12.5 volts.
// - the low supply mode bit chooses latched (0) or self-clearing (1) undervoltage faults.
// - a three-bit code selects the high supply limit, 0 none, else 20 to 35 volts.
// - the high supply mode bit chooses latched (0) or self-clearing (1) overvoltage faults.
// - a three-bit code bounds automatic retries, 0 unlimited, else 2 to 20 attempts.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module mfr_top
  import mfr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [DATA_W-1:0] bus_rdata,
  input  wire logic              current_lock_raw,
  input  wire logic [MV_W-1:0]   supply_mv,
  input  wire logic              lock_retry_wait_done,
  output logic                   lock_retry_wait_run,
  output mfr_stage_t             stage_mode,
  output logic                   fault_indicator_pin_n,
  output logic                   irq
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [CFG_W-1:0]       cfg_q;
  logic [ST_W-1:0]        status_q;
  logic [ST_W-1:0]        status_set;
  logic [ST_W-1:0]        mask_q;
  logic [RETRY_W-1:0]     retry_cnt_q;
  logic [1:0]             lk_resp_q;
  logic                   uv_fault_q;
  logic                   ov_fault_q;
  logic                   filt_q;
  logic                   lock_filt;
  logic                   lock_evt;
  logic                   clear_cmd;
  logic                   status_rd;
  logic                   uv_cond;
  logic                   ov_cond;
  logic                   retry_left;
  logic [LOCK_MODE_W-1:0] lock_mode;
  logic [LIM_W-1:0]       retry_code;
  logic [RETRY_W-1:0]     retry_lim;
  logic [MV_W-1:0]        uv_lim;
  logic [MV_W-1:0]        ov_lim;
  mfr_lock_state_t        lk_state_q;
  mfr_lock_state_t        lk_state_d;

  assign lock_mode  = cfg_q[LOCK_MODE_LSB +: LOCK_MODE_W];
  assign retry_code = cfg_q[RETRY_LSB +: LIM_W];
  assign retry_lim  = mfr_retry_limit(retry_code);
  assign uv_lim     = mfr_low_limit_mv(cfg_q[UV_LIM_LSB +: LIM_W]);
  assign ov_lim     = mfr_high_limit_mv(cfg_q[OV_LIM_LSB +: LIM_W]);
  assign clear_cmd  = bus_wr && bus_addr == ADDR_CTRL && bus_wdata[CTRL_CLEAR_BIT];
  assign status_rd  = bus_rd && bus_addr == ADDR_STATUS;

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_q <= CFG_RESET;
    end else if (bus_wr && bus_addr == ADDR_CFG) begin
      cfg_q <= bus_wdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_q <= ST_RESET;
    end else if (bus_wr && bus_addr == ADDR_MASK) begin
      mask_q <= bus_wdata[ST_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // lock detection
  // ------------------------------------------------------------
  mfr_filter #(
    .STEP_CYC (FILT_STEP_CYC),
    .CODE_W   (FILT_W)
  ) u_filter (
    .clk      (clk),
    .reset    (reset),
    .raw_in   (current_lock_raw),
    .code     (cfg_q[FILT_LSB +: FILT_W]),
    .filt_out (lock_filt)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filt_q <= 1'b0;
    end else begin
      filt_q <= lock_filt;
    end
  end

  // codes above report-only see no events at all
  assign lock_evt   = lock_filt && !filt_q && lock_mode <= LOCK_REPORT;
  assign retry_left = retry_lim == '0 || retry_cnt_q < retry_lim;

  always_comb begin
    lk_state_d = lk_state_q;
    case (lk_state_q)
      MFR_LK_IDLE: begin
        if (lock_evt && lock_mode <= LOCK_LATCH_MAX) begin
          lk_state_d = MFR_LK_LATCH;
        end else if (lock_evt && lock_mode <= LOCK_AUTO_MAX) begin
          lk_state_d = retry_left ? MFR_LK_WAIT : MFR_LK_LATCH;
        end
      end
      MFR_LK_WAIT: begin
        if (lock_retry_wait_done || clear_cmd) begin
          lk_state_d = MFR_LK_IDLE;
        end
      end
      MFR_LK_LATCH: begin
        if (clear_cmd) begin
          lk_state_d = MFR_LK_IDLE;
        end
      end
      default: lk_state_d = MFR_LK_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lk_state_q <= MFR_LK_IDLE;
    end else begin
      lk_state_q <= lk_state_d;
    end
  end

  // stage chosen at the event, kept while the fault stands
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lk_resp_q <= 2'h0;
    end else if (lk_state_q == MFR_LK_IDLE && lock_evt) begin
      lk_resp_q <= lock_mode[1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      retry_cnt_q <= '0;
    end else if (clear_cmd) begin
      retry_cnt_q <= RETRY_W'(lk_state_q == MFR_LK_IDLE && lk_state_d == MFR_LK_WAIT);
    end else if (lk_state_q == MFR_LK_IDLE && lk_state_d == MFR_LK_WAIT && retry_cnt_q != RETRY_MAX) begin
      retry_cnt_q <= retry_cnt_q + RETRY_W'(1);
    end
  end

  // ------------------------------------------------------------
  // supply limits
  // ------------------------------------------------------------
  assign uv_cond = uv_lim != '0 && supply_mv < uv_lim;
  assign ov_cond = ov_lim != '0 && supply_mv > ov_lim;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uv_fault_q <= 1'b0;
    end else if (uv_cond) begin
      uv_fault_q <= 1'b1;
    end else if (cfg_q[UV_MODE_BIT] || clear_cmd) begin
      uv_fault_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ov_fault_q <= 1'b0;
    end else if (ov_cond) begin
      ov_fault_q <= 1'b1;
    end else if (cfg_q[OV_MODE_BIT] || clear_cmd) begin
      ov_fault_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status and interrupt
  // ------------------------------------------------------------
  always_comb begin
    status_set           = '0;
    status_set[ST_LOCK]  = lock_evt;
    status_set[ST_UV]    = uv_cond && !uv_fault_q;
    status_set[ST_OV]    = ov_cond && !ov_fault_q;
    status_set[ST_LATCH] = lk_state_d == MFR_LK_LATCH && lk_state_q != MFR_LK_LATCH;
  end

  // a set in the clearing read cycle survives
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q <= ST_RESET;
    end else begin
      status_q <= (status_rd ? ST_RESET : status_q) | status_set;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // ------------------------------------------------------------
  // output stage and fault pin
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage_mode <= MFR_STAGE_RUN;
    end else if (lk_state_q != MFR_LK_IDLE) begin
      case (lk_resp_q)
        2'h0:    stage_mode <= MFR_STAGE_OFF;
        2'h1:    stage_mode <= MFR_STAGE_RECIRC;
        2'h2:    stage_mode <= MFR_STAGE_HS_ON;
        default: stage_mode <= MFR_STAGE_LS_ON;
      endcase
    end else if (uv_fault_q || ov_fault_q) begin
      stage_mode <= MFR_STAGE_OFF;
    end else begin
      stage_mode <= MFR_STAGE_RUN;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_indicator_pin_n <= 1'b1;
    end else begin
      fault_indicator_pin_n <= !(lk_state_q != MFR_LK_IDLE || uv_fault_q || ov_fault_q);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_retry_wait_run <= 1'b0;
    end else begin
      lock_retry_wait_run <= lk_state_q == MFR_LK_WAIT;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_rdata <= '0;
    end else if (!bus_rd) begin
      bus_rdata <= '0;
    end else begin
      case (bus_addr)
        ADDR_CFG:    bus_rdata <= DATA_W'(cfg_q);
        ADDR_STATUS: bus_rdata <= DATA_W'(status_q);
        ADDR_MASK:   bus_rdata <= DATA_W'(mask_q);
        ADDR_STATE: begin
          bus_rdata                              <= '0;
          bus_rdata[STS_RETRY_LSB +: RETRY_W]    <= retry_cnt_q;
          bus_rdata[STS_UV]                      <= uv_fault_q;
          bus_rdata[STS_OV]                      <= ov_fault_q;
          bus_rdata[STS_WAIT]                    <= lk_state_q == MFR_LK_WAIT;
          bus_rdata[STS_LATCH]                   <= lk_state_q == MFR_LK_LATCH;
        end
        default:     bus_rdata <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_latch_mode;
    lk_state_q == MFR_LK_IDLE && lock_evt && lock_mode <= LOCK_LATCH_MAX && !clear_cmd
      |=> lk_state_q == MFR_LK_LATCH ##1 !fault_indicator_pin_n && stage_mode != MFR_STAGE_RUN;
  endproperty
  a_latch_mode: assert property (p_latch_mode) else $error("latched lock code did not latch");

  property p_auto_wait;
    lk_state_q == MFR_LK_IDLE && lock_evt && lock_mode > LOCK_LATCH_MAX && lock_mode <= LOCK_AUTO_MAX
      && retry_left |=> lk_state_q == MFR_LK_WAIT ##1 lock_retry_wait_run;
  endproperty
  a_auto_wait: assert property (p_auto_wait) else $error("auto lock code did not start the retry wait");

  property p_auto_clear;
    lk_state_q == MFR_LK_WAIT && lock_retry_wait_done |=> lk_state_q == MFR_LK_IDLE;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("lock fault not cleared after retry wait");

  property p_report_only;
    lk_state_q == MFR_LK_IDLE && lock_evt && lock_mode == LOCK_REPORT
      |=> lk_state_q == MFR_LK_IDLE && status_q[ST_LOCK];
  endproperty
  a_report_only: assert property (p_report_only) else $error("report-only lock code acted or did not report");

  property p_disabled;
    lock_mode > LOCK_REPORT && lk_state_q == MFR_LK_IDLE |=> lk_state_q == MFR_LK_IDLE && !$rose(status_q[ST_LOCK]);
  endproperty
  a_disabled: assert property (p_disabled) else $error("lock event seen while detection disabled");

  property p_uv_set;
    uv_cond |=> uv_fault_q ##1 !fault_indicator_pin_n;
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("undervoltage not flagged");

  property p_uv_mode;
    uv_fault_q && !uv_cond |=> uv_fault_q == !($past(cfg_q[UV_MODE_BIT]) || $past(clear_cmd));
  endproperty
  a_uv_mode: assert property (p_uv_mode) else $error("undervoltage clear follows the wrong mode");

  property p_ov_set;
    ov_cond |=> ov_fault_q ##1 stage_mode == MFR_STAGE_OFF || lk_state_q != MFR_LK_IDLE;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("overvoltage did not stop the stage");

  property p_ov_mode;
    ov_fault_q && !ov_cond |=> ov_fault_q == !($past(cfg_q[OV_MODE_BIT]) || $past(clear_cmd));
  endproperty
  a_ov_mode: assert property (p_ov_mode) else $error("overvoltage clear follows the wrong mode");

  property p_retry_bound;
    lk_state_q == MFR_LK_IDLE && lock_evt && lock_mode > LOCK_LATCH_MAX && lock_mode <= LOCK_AUTO_MAX
      && retry_lim != '0 && retry_cnt_q >= retry_lim |=> lk_state_q == MFR_LK_LATCH;
  endproperty
  a_retry_bound: assert property (p_retry_bound) else $error("retries exceeded without latching");

  c_latch: cover property (lk_state_q == MFR_LK_IDLE ##1 lk_state_q == MFR_LK_LATCH);
  c_retry: cover property (lk_state_q == MFR_LK_WAIT ##1 lk_state_q == MFR_LK_IDLE);
  c_uv:    cover property ($rose(uv_fault_q) ##[1:50] $fell(uv_fault_q));
  c_irq:   cover property ($rose(irq));

endmodule

//--- design/mfr_pkg.sv
// package: register map, field layout, timing and lookup tables of the fault-response block
package mfr_pkg;

  // ------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------
  localparam int             ADDR_W      = 8;
  localparam int             DATA_W      = 32;
  localparam logic [7:0]     ADDR_CFG    = 8'h00;
  localparam logic [7:0]     ADDR_STATUS = 8'h04;
  localparam logic [7:0]     ADDR_MASK   = 8'h08;
  localparam logic [7:0]     ADDR_CTRL   = 8'h0C;
  localparam logic [7:0]     ADDR_STATE  = 8'h10;

  // ------------------------------------------------------------
  // configuration field layout
  // ------------------------------------------------------------
  localparam int             CFG_W          = 19;
  localparam logic [18:0]    CFG_RESET      = 19'h00000;
  localparam int             LOCK_MODE_LSB  = 15;
  localparam int             LOCK_MODE_W    = 4;
  localparam int             FILT_LSB       = 11;
  localparam int             FILT_W         = 4;
  localparam int             UV_LIM_LSB     = 8;
  localparam int             UV_MODE_BIT    = 7;
  localparam int             OV_LIM_LSB     = 4;
  localparam int             OV_MODE_BIT    = 3;
  localparam int             RETRY_LSB      = 0;
  localparam int             LIM_W          = 3;
  localparam logic [3:0]     LOCK_LATCH_MAX = 4'h3;
  localparam logic [3:0]     LOCK_AUTO_MAX  = 4'h7;
  localparam logic [3:0]     LOCK_REPORT    = 4'h8;

  // ------------------------------------------------------------
  // status, control and state register bits
  // ------------------------------------------------------------
  localparam int             ST_W           = 4;
  localparam int             ST_LOCK        = 0;
  localparam int             ST_UV          = 1;
  localparam int             ST_OV          = 2;
  localparam int             ST_LATCH       = 3;
  localparam logic [3:0]     ST_RESET       = 4'h0;
  localparam int             CTRL_CLEAR_BIT = 0;
  localparam int             STS_RETRY_LSB  = 0;
  localparam int             STS_UV         = 5;
  localparam int             STS_OV         = 6;
  localparam int             STS_WAIT       = 7;
  localparam int             STS_LATCH      = 8;

  // ------------------------------------------------------------
  // timing and widths
  // ------------------------------------------------------------
  localparam int             CLK_PERIOD_NS = 50;
  localparam int             FILT_STEP_NS  = 1000;
  localparam int             FILT_STEP_CYC = (FILT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int             MV_W          = 16;
  localparam int             RETRY_W       = 5;
  localparam logic [4:0]     RETRY_MAX     = 5'h1F;

  typedef enum logic [2:0] {
    MFR_LK_IDLE  = 3'b001,
    MFR_LK_WAIT  = 3'b010,
    MFR_LK_LATCH = 3'b100
  } mfr_lock_state_t;

  typedef enum logic [4:0] {
    MFR_STAGE_RUN    = 5'h01,
    MFR_STAGE_OFF    = 5'h02,
    MFR_STAGE_RECIRC = 5'h04,
    MFR_STAGE_HS_ON  = 5'h08,
    MFR_STAGE_LS_ON  = 5'h10
  } mfr_stage_t;

  // ------------------------------------------------------------
  // lookup tables
  // ------------------------------------------------------------
  // low supply limit in millivolts, zero means no limit
  function automatic logic [15:0] mfr_low_limit_mv(input logic [2:0] code);
    case (code)
      3'h1:    return 16'h1194;
      3'h2:    return 16'h1388;
      3'h3:    return 16'h157C;
      3'h4:    return 16'h1770;
      3'h5:    return 16'h1D4C;
      3'h6:    return 16'h2710;
      3'h7:    return 16'h30D4;
      default: return 16'h0000;
    endcase
  endfunction

  // high supply limit in millivolts, zero means no limit
  function automatic logic [15:0] mfr_high_limit_mv(input logic [2:0] code);
    case (code)
      3'h1:    return 16'h4E20;
      3'h2:    return 16'h57E4;
      3'h3:    return 16'h61A8;
      3'h4:    return 16'h6B6C;
      3'h5:    return 16'h7530;
      3'h6:    return 16'h7EF4;
      3'h7:    return 16'h88B8;
      default: return 16'h0000;
    endcase
  endfunction

  // allowed automatic retries, zero means unlimited
  function automatic logic [4:0] mfr_retry_limit(input logic [2:0] code);
    case (code)
      3'h1:    return 5'h02;
      3'h2:    return 5'h03;
      3'h3:    return 5'h05;
      3'h4:    return 5'h07;
      3'h5:    return 5'h0A;
      3'h6:    return 5'h0F;
      3'h7:    return 5'h14;
      default: return 5'h00;
    endcase
  endfunction

endpackage

//--- design/mfr_filter.sv
// module: programmable deglitch filter for the current-lock comparator
`timescale 1ns/1ps
module mfr_filter
  import mfr_pkg::*;
#(
  parameter int STEP_CYC = FILT_STEP_CYC,
  parameter int CODE_W   = FILT_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              raw_in,
  input  wire logic [CODE_W-1:0] code,
  output logic                   filt_out
);

  localparam int CNT_W = $clog2(STEP_CYC * ((1 << CODE_W) - 1) + 1);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] target;

  assign target = CNT_W'(code) * CNT_W'(STEP_CYC);

  // ------------------------------------------------------------
  // qualify time
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q    <= '0;
      filt_out <= 1'b0;
    end else if (!raw_in) begin
      cnt_q    <= '0;
      filt_out <= 1'b0;
    end else if (code == '0 || cnt_q >= target - CNT_W'(1)) begin
      filt_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + CNT_W'(1);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_filt_drop;
    !raw_in |=> !filt_out;
  endproperty
  a_filt_drop: assert property (p_filt_drop) else $error("filter output stayed high after input fell");

  property p_filt_qualify;
    $rose(filt_out) && code != '0 |-> $past(raw_in, STEP_CYC) && $past(raw_in, 1);
  endproperty
  a_filt_qualify: assert property (p_filt_qualify) else $error("filter passed a glitch shorter than one step");

endmodule

//--- test/mfr_top_test.sv
// testbench: fault-response block driven through its register bus and fault inputs
`timescale 1ns/1ps
module mfr_top_test;
  import mfr_pkg::*;
  logic              clk;
  logic              reset;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic              bus_wr;
  logic              bus_rd;
  logic [DATA_W-1:0] bus_rdata;
  logic              current_lock_raw;
  logic [MV_W-1:0]   supply_mv;
  logic              lock_retry_wait_done;
  logic              lock_retry_wait_run;
  mfr_stage_t        stage_mode;
  logic              fault_indicator_pin_n;
  logic              irq;
  int                fails;
  int                total_checks;
  logic [31:0]       rv;
  mfr_stage_t        stg[4];
  // supply limits in millivolts and retry counts per code, index 0 unused
  logic [15:0]       lo_mv[8];
  logic [15:0]       hi_mv[8];
  int                rlim[8];

  mfr_top mfr_top_i (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .current_lock_raw(current_lock_raw), .supply_mv(supply_mv),
    .lock_retry_wait_done(lock_retry_wait_done), .lock_retry_wait_run(lock_retry_wait_run),
    .stage_mode(stage_mode), .fault_indicator_pin_n(fault_indicator_pin_n), .irq(irq));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  function automatic logic [31:0] cfgw(input logic [3:0] m, input logic [3:0] f, input logic [2:0] lo,
                                       input logic lom, input logic [2:0] hi, input logic him,
                                       input logic [2:0] r);
    return {13'h0000, m, f, lo, lom, hi, him, r};
  endfunction

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // outputs after a fault, then status read-clear
  task automatic outs(input mfr_stage_t s, input logic pin, input logic [3:0] st);
    wait_cyc(4);
    chk({27'h0, stage_mode}, {27'h0, s});
    chk({31'h0, fault_indicator_pin_n}, {31'h0, pin});
    chk({31'h0, irq}, {31'h0, (st != 4'h0)});
    rd(ADDR_STATUS, rv);
    chk(rv, {28'h0, st});
  endtask

  task automatic clr();
    current_lock_raw <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0001);
    wait_cyc(4);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    chk({27'h0, stage_mode}, {27'h0, MFR_STAGE_RUN});
    chk({31'h0, fault_indicator_pin_n}, 32'h1);
    wr(ADDR_CFG, 32'hFFFF_FFFF);
    rd(ADDR_CFG, rv);
    chk(rv, 32'h0007_FFFF);
    wr(ADDR_STATE, 32'hFFFF_FFFF);
    rd(ADDR_STATE, rv);
    chk(rv, 32'h0000_0000);
    rd(8'h20, rv);
    chk(rv, 32'h0000_0000);
    wr(ADDR_MASK, 32'h0000_000F);
    rd(ADDR_MASK, rv);
    chk(rv, 32'h0000_000F);
  endtask

  task automatic t_latched();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CFG, cfgw(m[3:0], 4'h0, 3'h0, 1'b0, 3'h0, 1'b0, 3'h0));
      current_lock_raw <= 1'b1;
      outs(stg[m], 1'b0, 4'h9);
      wait_cyc(3);
      chk({31'h0, irq}, 32'h0);
      chk({27'h0, stage_mode}, {27'h0, stg[m]});
      clr();
      chk({27'h0, stage_mode}, {27'h0, MFR_STAGE_RUN});
      chk({31'h0, fault_indicator_pin_n}, 32'h1);
    end
  endtask

  // every retry code, auto modes in turn; code 0 must keep retrying past three retries, into a fourth wait
  task automatic t_retry();
    int n;
    for (int c = 0; c < 8; c++) begin
      n = (c == 0) ? 3 : rlim[c];
      wr(ADDR_CFG, cfgw({2'b01, c[1:0]}, 4'h0, 3'h0, 1'b0, 3'h0, 1'b0, c[2:0]));
      for (int k = 0; k < n; k++) begin
        current_lock_raw <= 1'b1;
        outs(stg[c[1:0]], 1'b0, 4'h1);
        chk({31'h0, lock_retry_wait_run}, 32'h1);
        current_lock_raw <= 1'b0;
        @(posedge clk);
        lock_retry_wait_done <= 1'b1;
        @(posedge clk);
        lock_retry_wait_done <= 1'b0;
        wait_cyc(4);
        chk({31'h0, fault_indicator_pin_n}, 32'h1);
        chk({31'h0, lock_retry_wait_run}, 32'h0);
      end
      current_lock_raw <= 1'b1;
      outs(stg[c[1:0]], 1'b0, (c == 0) ? 4'h1 : 4'h9);
      rd(ADDR_STATE, rv);
      chk(rv, (c == 0) ? 32'h0000_0084 : 32'h0000_0100 | n);
      clr();
    end
  endtask

  task automatic t_report_off();
    wr(ADDR_CFG, cfgw(4'h8, 4'h0, 3'h0, 1'b0, 3'h0, 1'b0, 3'h0));
    current_lock_raw <= 1'b1;
    outs(MFR_STAGE_RUN, 1'b1, 4'h1);
    current_lock_raw <= 1'b0;
    for (int m = 9; m < 16; m++) begin
      wr(ADDR_CFG, cfgw(m[3:0], 4'h0, 3'h0, 1'b0, 3'h0, 1'b0, 3'h0));
      current_lock_raw <= 1'b1;
      outs(MFR_STAGE_RUN, 1'b1, 4'h0);
      current_lock_raw <= 1'b0;
    end
  endtask

  // one cycle short of the filter time is dropped, the exact time passes
  task automatic t_filter();
    for (int f = 1; f < 16; f += 14) begin
      wr(ADDR_CFG, cfgw(4'h8, f[3:0], 3'h0, 1'b0, 3'h0, 1'b0, 3'h0));
      current_lock_raw <= 1'b1;
      repeat (f * FILT_STEP_CYC - 1) @(posedge clk);
      current_lock_raw <= 1'b0;
      outs(MFR_STAGE_RUN, 1'b1, 4'h0);
      current_lock_raw <= 1'b1;
      repeat (f * FILT_STEP_CYC) @(posedge clk);
      current_lock_raw <= 1'b0;
      outs(MFR_STAGE_RUN, 1'b1, 4'h1);
    end
  endtask

  task automatic t_supply();
    wr(ADDR_CFG, cfgw(4'h9, 4'h0, 3'h1, 1'b0, 3'h7, 1'b1, 3'h0));
    supply_mv <= 16'h1193;
    outs(MFR_STAGE_OFF, 1'b0, 4'h2);
    supply_mv <= 16'h1194;
    outs(MFR_STAGE_OFF, 1'b0, 4'h0);
    clr();
    chk({31'h0, fault_indicator_pin_n}, 32'h1);
    // both limits of every code, self-clearing modes, each boundary from both sides
    for (int c = 1; c < 8; c++) begin
      wr(ADDR_CFG, cfgw(4'h9, 4'h0, c[2:0], 1'b1, c[2:0], 1'b1, 3'h0));
      supply_mv <= lo_mv[c] - 16'h0001;
      outs(MFR_STAGE_OFF, 1'b0, 4'h2);
      supply_mv <= lo_mv[c];
      outs(MFR_STAGE_RUN, 1'b1, 4'h0);
      supply_mv <= hi_mv[c] + 16'h0001;
      outs(MFR_STAGE_OFF, 1'b0, 4'h4);
      supply_mv <= hi_mv[c];
      outs(MFR_STAGE_RUN, 1'b1, 4'h0);
    end
    wr(ADDR_CFG, cfgw(4'h9, 4'h0, 3'h0, 1'b0, 3'h1, 1'b0, 3'h0));
    supply_mv <= 16'h4E21;
    outs(MFR_STAGE_OFF, 1'b0, 4'h4);
    supply_mv <= 16'h4E20;
    outs(MFR_STAGE_OFF, 1'b0, 4'h0);
    clr();
    chk({31'h0, fault_indicator_pin_n}, 32'h1);
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #2_000_000;
    fails++;
    summarize();
  end

  initial begin
    fails = 0;
    total_checks = 0;
    stg = '{MFR_STAGE_OFF, MFR_STAGE_RECIRC, MFR_STAGE_HS_ON, MFR_STAGE_LS_ON};
    lo_mv = '{16'h0000, 16'h1194, 16'h1388, 16'h157C, 16'h1770, 16'h1D4C, 16'h2710, 16'h30D4};
    hi_mv = '{16'h0000, 16'h4E20, 16'h57E4, 16'h61A8, 16'h6B6C, 16'h7530, 16'h7EF4, 16'h88B8};
    rlim = '{0, 2, 3, 5, 7, 10, 15, 20};
    reset = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    current_lock_raw = 1'b0;
    supply_mv = 16'h5DC0;
    lock_retry_wait_done = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wait_cyc(1);
    t_regs();
    t_latched();
    t_retry();
    t_report_off();
    t_filter();
    t_supply();
    summarize();
  end
endmodule
